// ==== alarm_pkg.sv ====
// Package with register map, field positions and detector constants for the alarm status pair.
package alarm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offset 0x21 is not a multiple of four, so the offsets are indices; byte address = 4 * index.
  localparam logic [7:0] live_status_index    = 8'h20;
  localparam logic [7:0] latched_status_index = 8'h21;
  localparam logic [7:0] control_index        = 8'h24;
  localparam logic [7:0] status_reset_value   = 8'h00;
  localparam logic [7:0] control_reset_value  = 8'h00;

  // ----------------------------------------------------------------
  // Alarm bit positions
  // ----------------------------------------------------------------
  localparam int bit_unlocked   = 7;
  localparam int bit_line_ais   = 6;
  localparam int bit_fifo_slip  = 5;
  localparam int bit_add_j1     = 4;
  localparam int bit_clock_loss = 3;
  localparam int bit_ext_ais    = 2;
  localparam int bit_drop_j1    = 1;
  localparam int bit_byte_ais   = 0;

  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int ctl_analyzer_enable = 0;
  localparam int ctl_frame_qualified = 1;
  localparam int ctl_rx_ais_enable   = 2;
  localparam int ctl_rdi_enable      = 3;
  localparam int ctl_stuffing_select = 4;
  localparam int ctl_add_bus_timing  = 5;

  // ----------------------------------------------------------------
  // Detector constants
  // ----------------------------------------------------------------
  localparam int analyzer_window      = 1000;
  localparam int analyzer_error_limit = 30;
  localparam int analyzer_lock_bits   = 24;
  localparam int frame_bits           = 2928;
  localparam int ais_zero_limit       = 5;
  localparam int j1_frame_count       = 8;
  localparam int clock_stuck_min      = 12;
  localparam int clock_stuck_max      = 34;
  localparam int byte_ones_majority   = 5;

endpackage : alarm_pkg

// ==== frame_pulse_monitor.sv ====
// Loss-of-J1 monitor that counts consecutive frames with or without the pulse.
`timescale 1ns/100ps
module frame_pulse_monitor #(
  parameter int frames = alarm_pkg::j1_frame_count
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic frame_tick,
  input  wire logic pulse_seen,
  output logic      loss
);

  initial begin
    if (frames < 1 || frames > 255) begin
      $error("frame_pulse_monitor: frames out of range");
    end
  end

  logic [7:0] run;

  // Counts consecutive frames that disagree with the present alarm state.
  always_ff @(posedge ref_clk) begin
    if (reset || !enable) begin
      run  <= 8'h00;
      loss <= 1'b0;
    end else if (frame_tick) begin
      if (pulse_seen == loss) begin
        if (run == 8'(frames - 1)) begin
          run  <= 8'h00;
          loss <= ~loss;
        end else begin
          run <= run + 8'h01;
        end
      end else begin
        run <= 8'h00;
      end
    end
  end

endmodule : frame_pulse_monitor

// ==== alarm_status_register_pair.sv ====
// Alarm detectors and live/latched status register pair on an Avalon-MM slave.
`timescale 1ns/100ps
module alarm_status_register_pair #(
  parameter int stuck_cycles = 23,
  parameter int error_width  = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic        analyzer_bit_valid,
  input  wire logic        analyzer_bit_error,
  output logic [15:0]      analyzer_error_count,
  input  wire logic        tx_line_bit_valid,
  input  wire logic        tx_line_bit,
  input  wire logic        tx_frame_aligned,
  input  wire logic        tx_fifo_overflow,
  input  wire logic        tx_fifo_underflow,
  output logic             tx_fifo_recenter,
  input  wire logic        add_frame_tick,
  input  wire logic        add_composite_frame_pulse,
  input  wire logic        drop_frame_tick,
  input  wire logic        drop_composite_frame_pulse,
  input  wire logic        pointer_tracking_enable_pin,
  input  wire logic        ram_clock_input,
  input  wire logic        ais_clock_input,
  input  wire logic        external_ais_pin_n,
  input  wire logic        e1_byte_valid,
  input  wire logic [7:0]  e1_byte,
  output logic             rx_ais_generate,
  output logic             path_rdi_generate,
  output logic             line_ais_from_ais_clock
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  initial begin
    if (stuck_cycles < alarm_pkg::clock_stuck_min || stuck_cycles > alarm_pkg::clock_stuck_max) begin
      $error("alarm_status_register_pair: stuck_cycles outside 12 to 34");
    end
    if (error_width != 16) begin
      $error("alarm_status_register_pair: error counter must be 16 bits");
    end
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] count_ones(input logic [7:0] value);
    logic [3:0] sum;
    sum = 4'h0;
    for (int i = 0; i < 8; i++) begin
      sum = sum + {3'b000, value[i]};
    end
    return sum;
  endfunction : count_ones

  function automatic logic index_hit(input logic [9:0] addr, input logic [7:0] index);
    return addr[9:2] == index && addr[1:0] == 2'b00;
  endfunction : index_hit

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [7:0] control;
  logic [7:0] live;
  logic [7:0] latched;
  logic       hit_live;
  logic       hit_latched;
  logic       hit_control;
  logic       read_pending;

  assign hit_live    = index_hit(avs_address, alarm_pkg::live_status_index);
  assign hit_latched = index_hit(avs_address, alarm_pkg::latched_status_index);
  assign hit_control = index_hit(avs_address, alarm_pkg::control_index);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      control <= alarm_pkg::control_reset_value;
    end else if (avs_write && !avs_waitrequest && hit_control && avs_byteenable[0]) begin
      control <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Pattern analyzer
  // ----------------------------------------------------------------
  logic       analyzer_on;
  logic       unlocked;
  logic [9:0] window_bits;
  logic [5:0] window_errors;
  logic [4:0] good_run;

  assign analyzer_on = control[alarm_pkg::ctl_analyzer_enable];

  always_ff @(posedge ref_clk) begin
    if (reset || !analyzer_on) begin
      unlocked      <= 1'b1;
      window_bits   <= 10'h000;
      window_errors <= 6'h00;
      good_run      <= 5'h00;
    end else if (analyzer_bit_valid) begin
      if (unlocked) begin
        if (analyzer_bit_error) begin
          good_run <= 5'h00;
        end else if (good_run == 5'(alarm_pkg::analyzer_lock_bits - 1)) begin
          unlocked      <= 1'b0;
          good_run      <= 5'h00;
          window_bits   <= 10'h000;
          window_errors <= 6'h00;
        end else begin
          good_run <= good_run + 5'h01;
        end
      end else begin
        if (analyzer_bit_error && window_errors == 6'(alarm_pkg::analyzer_error_limit - 1)) begin
          unlocked <= 1'b1;
        end
        if (window_bits == 10'(alarm_pkg::analyzer_window - 1)) begin
          window_bits   <= 10'h000;
          window_errors <= 6'h00;
        end else begin
          window_bits   <= window_bits + 10'h001;
          window_errors <= window_errors + {5'h00, analyzer_bit_error};
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      analyzer_error_count <= 16'h0000;
    end else if (analyzer_on && !unlocked && analyzer_bit_valid && analyzer_bit_error
                 && analyzer_error_count != 16'hffff) begin
      analyzer_error_count <= analyzer_error_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Transmit line AIS
  // ----------------------------------------------------------------
  logic [11:0] frame_pos;
  logic [2:0]  zeros;
  logic        prev_few;
  logic        prev_many;
  logic        line_ais;
  logic        this_few;
  logic        frame_end;

  assign frame_end = tx_line_bit_valid && frame_pos == 12'(alarm_pkg::frame_bits - 1);
  assign this_few  = {1'b0, zeros} + {3'b000, ~tx_line_bit} <= 4'(alarm_pkg::ais_zero_limit);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_pos <= 12'h000;
      zeros     <= 3'h0;
      prev_few  <= 1'b0;
      prev_many <= 1'b0;
      line_ais  <= 1'b0;
    end else begin
      if (control[alarm_pkg::ctl_frame_qualified] && tx_frame_aligned) begin
        line_ais <= 1'b0;
      end
      if (tx_line_bit_valid) begin
        if (frame_end) begin
          frame_pos <= 12'h000;
          zeros     <= 3'h0;
          prev_few  <= this_few;
          prev_many <= !this_few;
          if (this_few && prev_few && (!control[alarm_pkg::ctl_frame_qualified]
                                       || !tx_frame_aligned)) begin
            line_ais <= 1'b1;
          end else if (!this_few && prev_many) begin
            line_ais <= 1'b0;
          end
        end else begin
          frame_pos <= frame_pos + 12'h001;
          if (!tx_line_bit && zeros != 3'h7) begin
            zeros <= zeros + 3'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit FIFO slip
  // ----------------------------------------------------------------
  logic fifo_slip;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fifo_slip        <= 1'b0;
      tx_fifo_recenter <= 1'b0;
    end else begin
      fifo_slip        <= tx_fifo_overflow || tx_fifo_underflow;
      tx_fifo_recenter <= tx_fifo_overflow || tx_fifo_underflow;
    end
  end

  // ----------------------------------------------------------------
  // J1 loss monitors
  // ----------------------------------------------------------------
  logic add_j1_loss;
  logic drop_j1_loss;

  frame_pulse_monitor add_monitor (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .enable     (control[alarm_pkg::ctl_add_bus_timing]),
    .frame_tick (add_frame_tick),
    .pulse_seen (add_composite_frame_pulse),
    .loss       (add_j1_loss)
  );

  frame_pulse_monitor drop_monitor (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .enable     (!pointer_tracking_enable_pin),
    .frame_tick (drop_frame_tick),
    .pulse_seen (drop_composite_frame_pulse),
    .loss       (drop_j1_loss)
  );

  // ----------------------------------------------------------------
  // AIS clock loss
  // ----------------------------------------------------------------
  logic       ram_clock_last;
  logic       ais_clock_last;
  logic [5:0] stuck_count;
  logic       clock_loss;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ram_clock_last <= 1'b0;
      ais_clock_last <= 1'b0;
      stuck_count    <= 6'h00;
      clock_loss     <= 1'b0;
    end else begin
      ram_clock_last <= ram_clock_input;
      ais_clock_last <= ais_clock_input;
      if (ais_clock_input != ais_clock_last) begin
        stuck_count <= 6'h00;
        clock_loss  <= 1'b0;
      end else if (ram_clock_input && !ram_clock_last && !clock_loss) begin
        if (stuck_count == 6'(stuck_cycles - 1)) begin
          clock_loss <= 1'b1;
        end else begin
          stuck_count <= stuck_count + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // External AIS, E1 byte AIS, generation controls
  // ----------------------------------------------------------------
  logic ext_ais;
  logic byte_ais;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ext_ais           <= 1'b0;
      rx_ais_generate   <= 1'b0;
      path_rdi_generate <= 1'b0;
    end else begin
      ext_ais           <= !external_ais_pin_n;
      rx_ais_generate   <= !external_ais_pin_n && control[alarm_pkg::ctl_rx_ais_enable];
      path_rdi_generate <= !external_ais_pin_n && control[alarm_pkg::ctl_rdi_enable];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      byte_ais <= 1'b0;
    end else if (e1_byte_valid) begin
      byte_ais <= count_ones(e1_byte) >= 4'(alarm_pkg::byte_ones_majority);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      line_ais_from_ais_clock <= 1'b1;
    end else begin
      line_ais_from_ais_clock <= !control[alarm_pkg::ctl_stuffing_select];
    end
  end

  // ----------------------------------------------------------------
  // Status registers and bus slave
  // ----------------------------------------------------------------
  always_comb begin
    live                           = alarm_pkg::status_reset_value;
    live[alarm_pkg::bit_unlocked]  = analyzer_on && unlocked;
    live[alarm_pkg::bit_line_ais]  = line_ais;
    live[alarm_pkg::bit_fifo_slip] = fifo_slip;
    live[alarm_pkg::bit_add_j1]    = add_j1_loss;
    live[alarm_pkg::bit_clock_loss] = clock_loss;
    live[alarm_pkg::bit_ext_ais]   = ext_ais;
    live[alarm_pkg::bit_drop_j1]   = drop_j1_loss;
    live[alarm_pkg::bit_byte_ais]  = byte_ais;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latched <= alarm_pkg::status_reset_value;
    end else if (avs_read && !avs_waitrequest && hit_latched) begin
      latched <= live;
    end else begin
      latched <= latched | live;
    end
  end

  // One wait cycle per access; the answer comes on the second cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      read_pending <= 1'b0;
    end else begin
      read_pending <= (avs_read || avs_write) && avs_waitrequest;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !read_pending;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_response <= (hit_live || hit_latched || hit_control) ? 2'b00 : 2'b11;
      if (hit_live) begin
        avs_readdata <= {24'h000000, live};
      end else if (hit_latched) begin
        avs_readdata <= {24'h000000, latched | live};
      end else if (hit_control) begin
        avs_readdata <= {24'h000000, control};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

endmodule : alarm_status_register_pair

// ==== alarm_status_register_pair_properties.sv ====
// Checker for the port behaviour of the alarm status register pair.
`timescale 1ns/100ps
module alarm_status_register_pair_properties #(
  parameter int stuck_cycles = 23,
  parameter int error_width  = 16
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        analyzer_bit_error,
  input wire logic [15:0] analyzer_error_count,
  input wire logic        tx_fifo_overflow,
  input wire logic        tx_fifo_underflow,
  input wire logic        tx_fifo_recenter,
  input wire logic        external_ais_pin_n,
  input wire logic        rx_ais_generate,
  input wire logic        path_rdi_generate
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence req_first;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence read_first;
    avs_read && avs_waitrequest;
  endsequence
  sequence ext_held(lvl);
    (external_ais_pin_n == lvl)[*3];
  endsequence

  AST_ONE_WAIT: assert property (req_first |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_IDLE_NO_WAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised with no request");
  AST_UNMAPPED: assert property (read_first ##0 !(avs_address inside {10'h080, 10'h084, 10'h090})
    |-> ##2 (avs_response == 2'b11 && avs_readdata == 32'h0))
    else $error("unmapped read not refused");
  AST_MAPPED_OK: assert property (read_first ##0 (avs_address inside {10'h080, 10'h084})
    |-> ##2 (avs_response == 2'b00 && avs_readdata[31:8] == 24'h0))
    else $error("status read bad response or upper bits");
  AST_LIVE_EXT_LOW: assert property (ext_held(1'b0) ##0 read_first ##0 avs_address == 10'h080
    |-> ##2 avs_readdata[2])
    else $error("live external alarm missing");
  AST_LIVE_EXT_HIGH: assert property (ext_held(1'b1) ##0 read_first ##0 avs_address == 10'h080
    |-> ##2 !avs_readdata[2])
    else $error("live external alarm without pin");
  AST_RECENTER: assert property (1'b1
    |=> tx_fifo_recenter == $past(tx_fifo_overflow || tx_fifo_underflow))
    else $error("recenter not one cycle after slip");
  AST_NO_RDI: assert property (ext_held(1'b1) |-> !rx_ais_generate && !path_rdi_generate)
    else $error("ais or rdi generated without pin");
  AST_COUNT_HOLD: assert property (!analyzer_bit_error |=> $stable(analyzer_error_count))
    else $error("error count moved without error");

  cover property (read_first ##0 avs_address == 10'h084);
endmodule : alarm_status_register_pair_properties

bind alarm_status_register_pair alarm_status_register_pair_properties #(
  .stuck_cycles(stuck_cycles), .error_width(error_width)) chk (
  .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .analyzer_bit_error(analyzer_bit_error),
  .analyzer_error_count(analyzer_error_count), .tx_fifo_overflow(tx_fifo_overflow),
  .tx_fifo_underflow(tx_fifo_underflow), .tx_fifo_recenter(tx_fifo_recenter),
  .external_ais_pin_n(external_ais_pin_n), .rx_ais_generate(rx_ais_generate),
  .path_rdi_generate(path_rdi_generate));

// ==== avalon_host.sv ====
// Host processor model that performs Avalon-MM register cycles.
`timescale 1ns/100ps
module avalon_host (
  input  wire logic        ref_clk,
  output logic [9:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic [1:0]  avs_response
);
  initial begin
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end

  // The request is held until waitrequest is seen low, then released at that edge.
  task automatic bus(input logic is_wr, input logic [9:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic [1:0] resp);
    @(posedge ref_clk);
    avs_address <= addr;
    avs_writedata <= wdata;
    avs_read <= !is_wr;
    avs_write <= is_wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
endmodule : avalon_host

// ==== test_alarm_status_register_pair.sv ====
// Self-checking testbench for the alarm status register pair.
`timescale 1ns/100ps
module test_alarm_status_register_pair;
  logic        ref_clk = 1'b0, reset = 1'b1, ais_run = 1'b1;
  logic [9:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd_data;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, rd_resp;
  logic        analyzer_bit_valid = 1'b0, analyzer_bit_error = 1'b0;
  logic        tx_line_bit_valid = 1'b0, tx_line_bit = 1'b0, tx_frame_aligned = 1'b0;
  logic        tx_fifo_overflow = 1'b0, tx_fifo_underflow = 1'b0;
  logic        add_frame_tick = 1'b0, add_composite_frame_pulse = 1'b0;
  logic        drop_frame_tick = 1'b0, drop_composite_frame_pulse = 1'b0;
  logic        pointer_tracking_enable_pin = 1'b0, ram_clock_input = 1'b0;
  logic        ais_clock_input = 1'b0, external_ais_pin_n = 1'b1, e1_byte_valid = 1'b0;
  logic [7:0]  e1_byte = 8'h00;
  logic [15:0] analyzer_error_count;
  logic        tx_fifo_recenter, rx_ais_generate, path_rdi_generate, line_ais_from_ais_clock;
  int          fail_count = 0, n_compared = 0;

  always #4 ref_clk = ~ref_clk;

  // The AIS clock runs at half rate unless a test stops it.
  always @(posedge ref_clk) begin
    ram_clock_input <= ~ram_clock_input;
    if (ais_run) ais_clock_input <= ~ais_clock_input;
  end

  alarm_status_register_pair dut (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .analyzer_bit_valid(analyzer_bit_valid), .analyzer_bit_error(analyzer_bit_error),
    .analyzer_error_count(analyzer_error_count), .tx_line_bit_valid(tx_line_bit_valid),
    .tx_line_bit(tx_line_bit), .tx_frame_aligned(tx_frame_aligned),
    .tx_fifo_overflow(tx_fifo_overflow), .tx_fifo_underflow(tx_fifo_underflow),
    .tx_fifo_recenter(tx_fifo_recenter), .add_frame_tick(add_frame_tick),
    .add_composite_frame_pulse(add_composite_frame_pulse), .drop_frame_tick(drop_frame_tick),
    .drop_composite_frame_pulse(drop_composite_frame_pulse),
    .pointer_tracking_enable_pin(pointer_tracking_enable_pin),
    .ram_clock_input(ram_clock_input), .ais_clock_input(ais_clock_input),
    .external_ais_pin_n(external_ais_pin_n), .e1_byte_valid(e1_byte_valid), .e1_byte(e1_byte),
    .rx_ais_generate(rx_ais_generate), .path_rdi_generate(path_rdi_generate),
    .line_ais_from_ais_clock(line_ais_from_ais_clock));

  avalon_host host (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response));

  // ----------------------------------------------------------------
  // Helper tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [9:0] addr, input logic [7:0] exp);
    host.bus(1'b0, addr, 32'h0, rd_data, rd_resp);
    check($sformatf("register %h", addr), rd_data, {24'h0, exp});
  endtask : rd

  task automatic wr(input logic [9:0] addr, input logic [7:0] d);
    host.bus(1'b1, addr, {24'h0, d}, rd_data, rd_resp);
  endtask : wr

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic frames(input int n, input logic p);
    repeat (n) begin
      @(posedge ref_clk);
      {add_frame_tick, drop_frame_tick} <= 2'b11;
      {add_composite_frame_pulse, drop_composite_frame_pulse} <= {p, p};
      @(posedge ref_clk);
      {add_frame_tick, drop_frame_tick} <= 2'b00;
    end
  endtask : frames

  task automatic line(input int n, input logic zeros);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      tx_line_bit_valid <= 1'b1;
      tx_line_bit <= zeros ? i[0] : 1'b1;
    end
    @(posedge ref_clk);
    tx_line_bit_valid <= 1'b0;
  endtask : line

  task automatic ana(input int n, input logic err);
    repeat (n) begin
      @(posedge ref_clk);
      {analyzer_bit_valid, analyzer_bit_error} <= {1'b1, err};
    end
    @(posedge ref_clk);
    {analyzer_bit_valid, analyzer_bit_error} <= 2'b00;
  endtask : ana

  task automatic e1(input logic [7:0] b);
    @(posedge ref_clk);
    {e1_byte_valid, e1_byte} <= {1'b1, b};
    @(posedge ref_clk);
    e1_byte_valid <= 1'b0;
  endtask : e1

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    tick(20);
    reset <= 1'b0;
    rd(10'h080, 8'h00);
    rd(10'h084, 8'h00);
    host.bus(1'b0, 10'h3fc, 32'h0, rd_data, rd_resp);
    check("unmapped response", {30'h0, rd_resp}, 32'h3);
    wr(10'h080, 8'hff);
    rd(10'h080, 8'h00);
    check("ais clock source", {31'h0, line_ais_from_ais_clock}, 32'h1);
    wr(10'h090, 8'h10);
    tick(3);
    check("ais clock source", {31'h0, line_ais_from_ais_clock}, 32'h0);
    external_ais_pin_n <= 1'b0;
    tick(3);
    rd(10'h080, 8'h04);
    wr(10'h090, 8'h0c);
    tick(3);
    check("rx ais", {31'h0, rx_ais_generate}, 32'h1);
    check("path rdi", {31'h0, path_rdi_generate}, 32'h1);
    rd(10'h084, 8'h04);
    rd(10'h084, 8'h04);
    external_ais_pin_n <= 1'b1;
    tick(3);
    rd(10'h080, 8'h00);
    rd(10'h084, 8'h04);
    rd(10'h084, 8'h00);
    e1(8'h1f);
    rd(10'h080, 8'h01);
    e1(8'h0f);
    rd(10'h080, 8'h00);
    rd(10'h084, 8'h01);
    @(posedge ref_clk) tx_fifo_overflow <= 1'b1;
    @(posedge ref_clk) tx_fifo_overflow <= 1'b0;
    rd(10'h084, 8'h20);
    @(posedge ref_clk) tx_fifo_underflow <= 1'b1;
    @(posedge ref_clk) tx_fifo_underflow <= 1'b0;
    rd(10'h084, 8'h20);
    ais_run <= 1'b0;
    tick(80);
    rd(10'h080, 8'h08);
    ais_run <= 1'b1;
    tick(4);
    rd(10'h080, 8'h00);
    rd(10'h084, 8'h08);
    wr(10'h090, 8'h20);
    frames(9, 1'b0);
    rd(10'h080, 8'h12);
    pointer_tracking_enable_pin <= 1'b1;
    tick(3);
    rd(10'h080, 8'h10);
    pointer_tracking_enable_pin <= 1'b0;
    frames(9, 1'b1);
    rd(10'h080, 8'h00);
    rd(10'h084, 8'h12);
    wr(10'h090, 8'h00);
    line(3 * 2928, 1'b0);
    rd(10'h080, 8'h40);
    line(3 * 2928, 1'b1);
    rd(10'h080, 8'h00);
    wr(10'h090, 8'h02);
    tx_frame_aligned <= 1'b1;
    line(3 * 2928, 1'b0);
    rd(10'h080, 8'h00);
    tx_frame_aligned <= 1'b0;
    line(2928, 1'b0);
    rd(10'h080, 8'h40);
    tx_frame_aligned <= 1'b1;
    tick(2);
    rd(10'h080, 8'h00);
    wr(10'h090, 8'h01);
    ana(24, 1'b0);
    rd(10'h080, 8'h00);
    ana(30, 1'b1);
    rd(10'h080, 8'h80);
    check("error count", {16'h0, analyzer_error_count}, 32'(alarm_pkg::analyzer_error_limit));
    ana(4, 1'b1);
    check("error count", {16'h0, analyzer_error_count}, 32'(alarm_pkg::analyzer_error_limit));
    wr(10'h090, 8'h00);
    tick(2);
    rd(10'h080, 8'h00);
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end
endmodule : test_alarm_status_register_pair
